//--- core/supervisor_pkg.sv
// How it works
// R1: low rail flag asserts channel hold
// R2: window upper flag high asserts channel four
// R3: each channel picks its own delay
// R4: pulled-up config gives long fixed delay
// R5: open config gives short fixed delay
// R6: programmed delay spans short to very long
// R7: config pin pulled low briefly at startup
// R8: board fits large enough timing capacitor
// R9: programmed delay is charge time to threshold
// R10: timer held cleared while hold asserted; code clears it only while fault present or config unsensed, counts during hold
// R11: release only when timer ends, condition met
// R12: manual hold low forces primary hold
// R13: primary released once manual high, rail good
// R14: outside drives manual hold to defined level
// R15: watchdog counts once primary hold releases
// R16: any kick edge reloads watchdog count
// R17: missed kick asserts watchdog timeout output
// R18: timeout latches, kicks do not clear it
// R19: timeout clears only by primary hold asserted
// R20: legacy wiring ties timeout to manual input
// R21: build option inverts all output polarities; code inverts only the hold and timeout outputs
// R22: fault asserts hold at once, release delayed
// R23: watchdog period is fixed after last kick
// R24: watchdog held at reload during primary hold
// R25: delays are cycle counters from clock rate
package supervisor_pkg;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int unsigned clk_hz          = 100_000_000; // system clock rate
    localparam int unsigned long_delay_ms   = 300;         // pulled-up config delay
    localparam int unsigned short_delay_ms  = 20;          // open config delay
    localparam int unsigned watchdog_ms     = 610;         // kick window
    localparam int unsigned prog_min_us     = 1400;        // shortest programmed delay
    localparam int unsigned prog_max_ms     = 10_000;      // longest programmed delay
    localparam int unsigned sense_ns        = 1000;        // config pin discharge pulse
    localparam int unsigned cycles_per_ms   = clk_hz / 1000;
    localparam int unsigned long_cycles     = long_delay_ms * cycles_per_ms;
    localparam int unsigned short_cycles    = short_delay_ms * cycles_per_ms;
    localparam int unsigned watchdog_cycles = watchdog_ms * cycles_per_ms;
    localparam int unsigned prog_min_cycles = prog_min_us * (clk_hz / 1_000_000);
    localparam int unsigned prog_max_cycles = prog_max_ms * cycles_per_ms;
    localparam int unsigned sense_cycles    = (sense_ns * (clk_hz / 1_000_000) + 999) / 1000;
    localparam int unsigned count_w         = 30;          // wide enough for ten seconds
    localparam int unsigned channels        = 4;           // supervisor channels

    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [1:0] {
        delay_long,    // config pin pulled up
        delay_short,   // config pin left open
        delay_prog     // capacitor on config pin
    } delay_mode_t;

    // analog side of one delay config pin
    typedef struct packed {
        logic pin_high;    // pin reads high when released
        logic cap_charged; // timing node reached threshold
    } delay_pin_t;

    // discharge and charge controls for one config pin
    typedef struct packed {
        logic discharge_oe_n; // low while pulling pin low
        logic charge_en;      // constant current source on
    } delay_drive_t;

endpackage : supervisor_pkg

//--- core/sync_two.sv
`timescale 1ns/100ps
// ***************************************************************
// two flop synchroniser
// ***************************************************************
module sync_two #(
    parameter int unsigned width = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [width-1:0] d,
    output logic      [width-1:0] q
);
    logic [width-1:0] meta; // first stage, read only by q

    // two stages, reset to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sync_two

//--- core/delay_channel.sv
`timescale 1ns/100ps
// ***************************************************************
// one channel hold with release delay
// ***************************************************************
module delay_channel (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              fault,      // hold condition
    input  wire logic                              mode_valid, // config sensed
    input  wire supervisor_pkg::delay_mode_t       mode,
    input  wire logic                              cap_charged,
    output logic                                   hold,
    output logic                                   charge_en
);
    logic [supervisor_pkg::count_w-1:0] count;      // delay timer
    logic [supervisor_pkg::count_w-1:0] end_count;  // terminal for fixed modes
    logic                               done;       // timer end point reached

    assign end_count = (mode == supervisor_pkg::delay_long)
                     ? supervisor_pkg::count_w'(supervisor_pkg::long_cycles)
                     : supervisor_pkg::count_w'(supervisor_pkg::short_cycles);
    // programmed mode ends on capacitor threshold, clamped to the span
    assign done = (mode == supervisor_pkg::delay_prog)
                ? ((cap_charged && count >= supervisor_pkg::count_w'(supervisor_pkg::prog_min_cycles))
                   || count >= supervisor_pkg::count_w'(supervisor_pkg::prog_max_cycles)) // R6 R9
                : (count >= end_count - 1'b1); // R4 R5 R25

    // hold asserts at once, releases after the delay
    always_ff @(posedge clk) begin
        if (rst) begin
            hold      <= 1'b1;
            count     <= '0;
            charge_en <= 1'b0;
        end else if (fault || !mode_valid) begin
            hold      <= 1'b1;  // R1 R22
            count     <= '0;    // R10
            charge_en <= 1'b0;
        end else if (hold) begin
            charge_en <= 1'b1;
            if (done) begin
                hold      <= 1'b0; // R11
                charge_en <= 1'b0;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    property p_fault_holds;
        @(posedge clk) disable iff (rst) fault |=> hold;
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("hold missing after fault"); // R22

    property p_timer_cleared;
        @(posedge clk) disable iff (rst) fault |=> (count == '0);
    endproperty
    a_timer_cleared: assert property (p_timer_cleared) else $error("timer not cleared"); // R10

    property p_release_at_end;
        @(posedge clk) disable iff (rst) $fell(hold) |-> $past(done) && !$past(fault);
    endproperty
    a_release_at_end: assert property (p_release_at_end) else $error("early release"); // R11
endmodule : delay_channel

//--- core/supply_supervisor_reset_watchdog.sv
`timescale 1ns/100ps
// ***************************************************************
// four channel supply supervisor with watchdog
// ***************************************************************
module supply_supervisor_reset_watchdog #(
    parameter bit active_high = 1'b0, // output polarity build option
    parameter int unsigned watchdog_cycles = supervisor_pkg::watchdog_cycles,
    parameter int unsigned sense_cycles    = supervisor_pkg::sense_cycles
) (
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    input  wire logic [2:0]                              rail_sense_in,      // channels 1-3 good
    input  wire logic                                    window_lower_sense, // above falling level
    input  wire logic                                    window_upper_sense, // above rising level
    input  wire logic                                    manual_hold_in_n,
    input  wire logic                                    watchdog_kick_in,
    input  wire supervisor_pkg::delay_pin_t [3:0]        delay_config_in,
    output supervisor_pkg::delay_drive_t    [3:0]        delay_drive_out,
    output logic [3:0]                                   channel_hold_out,
    output logic                                         watchdog_timeout_out
);
    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    localparam int unsigned sync_w = 15; // 3 rails, 4 single pins, 4 config pairs
    logic [sync_w-1:0] raw_in;   // all pins together
    logic [sync_w-1:0] sync_in;  // after two flops

    assign raw_in = {rail_sense_in, window_lower_sense, window_upper_sense,
                     manual_hold_in_n, watchdog_kick_in, delay_config_in};

    sync_two #(.width(sync_w)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (raw_in),
        .q   (sync_in)
    );

    logic [2:0]                        rail_good;    // channels 1-3 above threshold
    logic                              lower_good;   // window lower ok
    logic                              upper_over;   // window upper tripped
    logic                              manual_n;     // manual hold level
    logic                              kick;         // kick level
    supervisor_pkg::delay_pin_t [3:0]  pin_s;        // synced config pins

    assign rail_good  = sync_in[14:12];
    assign lower_good = sync_in[11];
    assign upper_over = sync_in[10];
    assign manual_n   = sync_in[9];
    assign kick       = sync_in[8];
    assign pin_s      = sync_in[7:0];

    // ***************************************************************
    // startup config sensing
    // ***************************************************************
    logic [15:0]                         sense_count;  // discharge pulse timer
    logic                                sensing;      // pin pulled low now
    logic [2:0]                          settle;       // wait for synced read
    logic                                mode_valid;   // modes captured
    supervisor_pkg::delay_mode_t [3:0]   mode;         // per channel delay mode
    logic [3:0]                          pin_low_seen; // pin still low at early look

    // function: decide mode from sampled pin level and charge
    function automatic supervisor_pkg::delay_mode_t decode_mode(input logic high_now,
                                                                input logic low_after);
        if (high_now && !low_after)
            return supervisor_pkg::delay_long;   // pulled up, recovers at once
        else if (low_after)
            return supervisor_pkg::delay_prog;   // capacitor holds it low
        else
            return supervisor_pkg::delay_short;  // open pin floats up
    endfunction : decode_mode

    // pull each config pin low, then sample on release
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_count  <= '0;
            sensing      <= 1'b1;
            settle       <= '0;
            mode_valid   <= 1'b0;
            mode         <= '{default: supervisor_pkg::delay_short};
            pin_low_seen <= '0;
        end else if (sensing) begin
            // R7
            if (sense_count >= 16'(sense_cycles - 1))
                sensing <= 1'b0;
            else
                sense_count <= sense_count + 1'b1;
        end else if (!mode_valid) begin
            settle <= settle + 1'b1;
            // early look: a pulled-up pin is already back high
            if (settle == 3'h3) begin
                for (int i = 0; i < supervisor_pkg::channels; i++) begin
                    pin_low_seen[i] <= !pin_s[i].pin_high;
                end
            end
            // late look: a capacitor still holds the pin low
            if (settle == 3'h7) begin
                mode_valid <= 1'b1;
                for (int i = 0; i < supervisor_pkg::channels; i++) begin
                    mode[i] <= decode_mode(!pin_low_seen[i], !pin_s[i].pin_high); // R3
                end
            end
        end
    end

    // ***************************************************************
    // channels
    // ***************************************************************
    logic [3:0] fault;   // per channel hold condition
    logic [3:0] hold;    // per channel held state
    logic [3:0] charge;  // per channel charge source

    assign fault[0] = !rail_good[0] || !manual_n;  // R1 R12 R13
    assign fault[1] = !rail_good[1];               // R1
    assign fault[2] = !rail_good[2];               // R1
    assign fault[3] = !lower_good || upper_over;   // R1 R2

    for (genvar c = 0; c < 4; c++) begin : g_chan
        delay_channel u_chan (
            .clk         (clk),
            .rst         (rst),
            .fault       (fault[c]),
            .mode_valid  (mode_valid),
            .mode        (mode[c]),
            .cap_charged (pin_s[c].cap_charged),
            .hold        (hold[c]),
            .charge_en   (charge[c])
        );
    end

    // ***************************************************************
    // watchdog
    // ***************************************************************
    logic [supervisor_pkg::count_w-1:0] watchdog_counter; // cycles left
    logic                               kick_d;           // kick last cycle
    logic                               kick_edge;        // either edge
    logic                               timed_out;        // latched timeout

    assign kick_edge = kick ^ kick_d;

    // countdown from release, reload on edges, latch on expiry
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_counter <= supervisor_pkg::count_w'(watchdog_cycles);
            kick_d           <= 1'b0;
            timed_out        <= 1'b0;
        end else begin
            kick_d <= kick;
            if (hold[0]) begin
                watchdog_counter <= supervisor_pkg::count_w'(watchdog_cycles); // R24 R15
                timed_out        <= 1'b0;                                       // R19
            end else if (timed_out) begin
                watchdog_counter <= watchdog_counter;                           // R18
            end else if (kick_edge) begin
                watchdog_counter <= supervisor_pkg::count_w'(watchdog_cycles); // R16 R23
            end else if (watchdog_counter <= 1) begin
                timed_out        <= 1'b1;                                       // R17
            end else begin
                watchdog_counter <= watchdog_counter - 1'b1;
            end
        end
    end

    // ***************************************************************
    // outputs, registered with polarity option
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_hold_out     <= active_high ? 4'hf : 4'h0;
            watchdog_timeout_out <= active_high ? 1'b0 : 1'b1;
            delay_drive_out      <= '0;
        end else begin
            channel_hold_out     <= active_high ? hold : ~hold;            // R21
            watchdog_timeout_out <= active_high ? timed_out : ~timed_out;  // R21
            for (int i = 0; i < 4; i++) begin
                // pull every pin low while sensing, then drain only a timing capacitor
                delay_drive_out[i].discharge_oe_n <= !(sensing || (mode_valid && !charge[i]
                    && mode[i] == supervisor_pkg::delay_prog)); // R7 R10
                delay_drive_out[i].charge_en      <= charge[i];
            end
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    property p_manual_forces;
        @(posedge clk) disable iff (rst) !manual_n |=> hold[0];
    endproperty
    a_manual_forces: assert property (p_manual_forces) else $error("manual hold ignored"); // R12

    property p_window_upper;
        @(posedge clk) disable iff (rst) upper_over |=> hold[3];
    endproperty
    a_window_upper: assert property (p_window_upper) else $error("window upper ignored"); // R2

    property p_latched;
        @(posedge clk) disable iff (rst) timed_out && !hold[0] |=> timed_out;
    endproperty
    a_latched: assert property (p_latched) else $error("timeout cleared by kick"); // R18

    property p_clear_by_hold;
        @(posedge clk) disable iff (rst) $fell(timed_out) |-> $past(hold[0]);
    endproperty
    a_clear_by_hold: assert property (p_clear_by_hold) else $error("bad timeout clear"); // R19

    property p_no_timeout_in_hold;
        @(posedge clk) disable iff (rst) hold[0] |=> !timed_out;
    endproperty
    a_no_timeout_in_hold: assert property (p_no_timeout_in_hold) else $error("timeout in hold"); // R24

    property p_output_polarity;
        @(posedge clk) disable iff (rst)
            1'b1 |=> channel_hold_out == (active_high ? $past(hold) : ~$past(hold));
    endproperty
    a_output_polarity: assert property (p_output_polarity) else $error("wrong polarity"); // R21

    c_timeout: cover property (@(posedge clk) disable iff (rst) $rose(timed_out));
    c_release: cover property (@(posedge clk) disable iff (rst) $fell(hold[0]));
    c_kick:    cover property (@(posedge clk) disable iff (rst) kick_edge && !hold[0]);
endmodule : supply_supervisor_reset_watchdog

//--- tb/config_pin_model.sv
`timescale 1ns/100ps
// ***************************************************************
// capacitor timing node on each delay config pin
// ***************************************************************
module config_pin_model #(
    parameter int unsigned charge_cycles = 200, // cycles to reach threshold
    parameter int          long_ch       = 2    // channel with a pull-up, no capacitor
) (
    input  wire supervisor_pkg::delay_drive_t [3:0] drive,
    input  wire logic                                clk,
    output supervisor_pkg::delay_pin_t        [3:0] pins
);
    int unsigned level [4] = '{default: 0}; // charge held on each node

    // charge integrates while the source is on, drains while pulled low
    always @(posedge clk) begin
        for (int c = 0; c < 4; c++) begin
            if (drive[c].discharge_oe_n !== 1'b1 || drive[c].charge_en !== 1'b1) begin
                level[c] <= 0;
            end else if (level[c] < charge_cycles) begin
                level[c] <= level[c] + 1;
            end
        end
    end

    // a large capacitor keeps the node low, so only the long_ch pull-up pin reads high
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            pins[c].pin_high    = (c == long_ch) && drive[c].discharge_oe_n === 1'b1;
            pins[c].cap_charged = (level[c] >= charge_cycles);
        end
    end
endmodule : config_pin_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
// ***************************************************************
// self-checking bench for the supply supervisor
// ***************************************************************
module tb_top;
    localparam int unsigned wd_cycles = 50;   // shortened kick window
    localparam logic        asrt      = 1'b0; // active-low build, legacy wiring allowed
    localparam logic        rlse      = ~asrt; // released output level
    logic                                clk;
    logic                                rst;
    logic [2:0]                          rail_sense_in;
    logic                                window_lower_sense;
    logic                                window_upper_sense;
    logic                                manual_hold_in_n;
    logic                                watchdog_kick_in;
    supervisor_pkg::delay_pin_t   [3:0]  delay_config_in;
    supervisor_pkg::delay_drive_t [3:0]  delay_drive_out;
    logic [3:0]                          channel_hold_out;
    logic                                watchdog_timeout_out;
    int                                  n_mismatch = 0; // failed comparisons
    int                                  checked    = 0; // all comparisons
    logic [31:0]                         seed = 32'hf45f; // xorshift state
    int                                  held = 4;        // model: channels held, bit 2 long
    int                                  n;
    logic [3:0]                          low_seen;

    supply_supervisor_reset_watchdog #(
        .active_high     (1'b0),
        .watchdog_cycles (wd_cycles),
        .sense_cycles    (2)
    ) supply_supervisor_reset_watchdog_i (
        .clk                  (clk),
        .rst                  (rst),
        .rail_sense_in        (rail_sense_in),
        .window_lower_sense   (window_lower_sense),
        .window_upper_sense   (window_upper_sense),
        .manual_hold_in_n     (manual_hold_in_n),
        .watchdog_kick_in     (watchdog_kick_in),
        .delay_config_in      (delay_config_in),
        .delay_drive_out      (delay_drive_out),
        .channel_hold_out     (channel_hold_out),
        .watchdog_timeout_out (watchdog_timeout_out)
    );

    config_pin_model #(.charge_cycles(200)) config_pin_model_i (
        .drive (delay_drive_out),
        .clk   (clk),
        .pins  (delay_config_in)
    );

    // ***************************************************************
    // clock, helpers
    // ***************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // xorshift pseudo-random source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // expected hold pins from the model's held mask
    function automatic logic [31:0] hold_exp(int m);
        return {28'h0, (asrt ? m[3:0] : ~m[3:0])};
    endfunction : hold_exp

    // one comparison, counted and reported on mismatch
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // the single end of the run
    task automatic give_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // drive one fault source: 0 manual, 1-2 rails, 3 window low, 4 window high
    task automatic set_fault(int k, logic bad);
        case (k)
            0: manual_hold_in_n = ~bad;
            1: rail_sense_in[1] = ~bad;
            2: rail_sense_in[2] = ~bad;
            3: window_lower_sense = ~bad;
            default: window_upper_sense = bad;
        endcase
    endtask : set_fault

    // ***************************************************************
    // watchdog on the whole run
    // ***************************************************************
    initial begin
        #2_500_000;
        n_mismatch++;
        give_verdict();
    end

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        rst = 1'b1;
        rail_sense_in = 3'h7;
        window_lower_sense = 1'b1;
        window_upper_sense = 1'b0;
        manual_hold_in_n = 1'b1;
        watchdog_kick_in = 1'b0;
        low_seen = 4'h0;
        repeat (12) @(negedge clk);
        check("hold_in_reset", channel_hold_out, hold_exp(15));
        check("timeout_in_reset", watchdog_timeout_out, rlse);
        rst = 1'b0;
        // each config pin pulled low once after power-on
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            for (int c = 0; c < 4; c++) begin
                if (delay_drive_out[c].discharge_oe_n === 1'b0) low_seen[c] = 1'b1;
            end
        end
        check("config_discharged", low_seen, 4'hf);
        for (int c = 0; c < 4; c++) low_seen[c] = delay_drive_out[c].discharge_oe_n;
        check("config_released", low_seen, 4'hf);
        // programmed release: not before the shortest programmed delay
        n = 20;
        while (channel_hold_out !== hold_exp(held) && n < 160000) begin
            @(negedge clk);
            n++;
        end
        check("released", channel_hold_out, hold_exp(held));
        check("delay_min", n >= supervisor_pkg::prog_min_cycles, 1);
        check("delay_max", n <= supervisor_pkg::prog_min_cycles + 100, 1);
        // kicks of random spacing keep the watchdog quiet
        for (int i = 0; i < 30; i++) begin
            repeat (1 + rnd() % 40) @(negedge clk);
            watchdog_kick_in = ~watchdog_kick_in;
            check("kicked", watchdog_timeout_out, rlse);
        end
        repeat (wd_cycles - 4) @(negedge clk);
        check("before_expiry", watchdog_timeout_out, rlse);
        repeat (12) @(negedge clk);
        check("expired", watchdog_timeout_out, asrt);
        for (int i = 0; i < 4; i++) begin
            repeat (5) @(negedge clk);
            watchdog_kick_in = ~watchdog_kick_in;
        end
        repeat (5) @(negedge clk);
        check("latched", watchdog_timeout_out, asrt);
        // faults on each source, window high first, manual last
        for (int k = 4; k >= 0; k--) begin
            set_fault(k, 1'b1);
            repeat (2) @(negedge clk);
            check("not_yet", channel_hold_out, hold_exp(held));
            repeat (3) @(negedge clk);
            held = held | (1 << (k == 4 ? 3 : k));
            check("fault_hold", channel_hold_out, hold_exp(held));
            check("timer_clear", delay_drive_out[k == 4 ? 3 : k].charge_en, 1'b0);
            check("cap_drained", delay_drive_out[k == 4 ? 3 : k].discharge_oe_n, k == 2);
            if (k == 0) begin
                repeat (4) @(negedge clk);
                check("timeout_cleared", watchdog_timeout_out, rlse);
                rail_sense_in[0] = 1'b0;
            end
            set_fault(k, 1'b0);
            repeat (wd_cycles + 20) @(negedge clk);
            check("still_held", channel_hold_out, hold_exp(held));
        end
        check("no_timeout_in_hold", watchdog_timeout_out, rlse);
        give_verdict();
    end
endmodule : tb_top
